// ### logic/multi_io_serial_flash_interface.sv
`timescale 1ns/1ps
// Behaviour
// - dual address phase takes two bits per cycle on lines 1:0
// - after dual address go to latency if needed, else to output
// - line values are disregarded during dual latency
// - device drivers on lines 1:0 stay off in dual latency
// - last dual latency cycle leads into dual output
// - dual reads drive two data bits per cycle on lines 1:0
// - output streams until chip select rises
// - pause stays active in dual phases unless quad enable is set, write-protect ignored in dual phases
// - quad address phase takes four bits per cycle on all lines
// - after quad address go to latency if needed, else to output
// - quad latency length comes from the latency count field
// - no drive and no use of the lines during quad latency
// - last quad latency cycle leads into quad output
// - quad reads drive four data bits per cycle on lines 3:0
// - quad enable ignores pause and write-protect, permits quad reads
// - low supply indication makes every command ignored
// - write commands rejected until power-up write delay elapses
// - deep sleep ignores all commands except the wake command
// - writes run only with a clock count multiple of eight
// - instruction captured msb first, one bit per rising edge
// - pause low freezes command, floats outputs, resumes same state
module multi_io_serial_flash_interface #(
    parameter int PUW_CYCLES = flash_io_pkg::PUW_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_enable_bit,
    input wire logic [3:0] latency_count_field,
    input wire logic write_inhibit_voltage,
    output logic rd_start,
    output logic [23:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic rd_ready,
    output logic wr_exec,
    output logic [7:0] wr_cmd,
    output logic deep_sleep_state,
    output logic write_allowed
);

    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] s3;
        logic [6:0] f;
        logic sck_d;
        logic cs_d;
        flash_io_pkg::phase_t state;
        logic quad;
        logic [7:0] cmd;
        logic [5:0] cnt;
        logic [2:0] clk_cnt;
        logic [31:0] am;
        logic [7:0] sh;
        logic [2:0] grp;
        logic drive;
        logic [3:0] dout;
        logic [3:0] oe;
        logic [19:0] puw_cnt;
        logic puw_done;
        logic sleep;
        logic pend_wr;
        logic pend_sleep;
        logic pend_wake;
        logic rd_start;
        logic [23:0] rd_addr;
        logic wr_exec;
        logic pop;
        logic flush;
    } core_t;

    core_t st_r;
    core_t st_nxt;
    logic [7:0] fifo_data;
    logic fifo_valid;

    // ------------------------------------------------------------
    // read data buffer between the core and the serial output
    // ------------------------------------------------------------
    byte_fifo #(
        .WIDTH(flash_io_pkg::FIFO_WIDTH),
        .DEPTH(flash_io_pkg::FIFO_DEPTH)
    ) u_rd_fifo (
        .clk(clk),
        .rst(rst),
        .flush(st_r.flush),
        .in_data(rd_data),
        .in_valid(rd_valid),
        .in_ready(rd_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(st_r.pop)
    );

    // ------------------------------------------------------------
    // interface sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic cs_hi;
        logic low;
        logic pause;
        logic [7:0] cmd_new;
        logic [31:0] am_new;
        logic [5:0] lat;
        logic [7:0] byte_v;
        rise = 1'b0;
        fall = 1'b0;
        cs_hi = 1'b0;
        low = 1'b0;
        pause = 1'b0;
        cmd_new = 8'h00;
        am_new = 32'h0000_0000;
        lat = 6'h00;
        byte_v = 8'h00;
        st_nxt = st_r;
        // three-flop synchroniser, a change counts once flops 2 and 3 agree
        st_nxt.s1 = {write_inhibit_voltage, cs_n, sck, io_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.f = (st_r.s2 & st_r.s3) | (st_r.f & (st_r.s2 ^ st_r.s3));
        st_nxt.sck_d = st_r.f[flash_io_pkg::PIN_SCK];
        st_nxt.cs_d = st_r.f[flash_io_pkg::PIN_CS];
        cs_hi = st_r.f[flash_io_pkg::PIN_CS];
        low = st_r.f[flash_io_pkg::PIN_LOW];
        // pause only exists while the quad enable bit is off
        pause = !quad_enable_bit && !cs_hi && !st_r.f[flash_io_pkg::PIN_PAUSE]
                && (st_r.state != flash_io_pkg::ST_IDLE);
        rise = st_r.f[flash_io_pkg::PIN_SCK] & ~st_r.sck_d & ~pause;
        fall = ~st_r.f[flash_io_pkg::PIN_SCK] & st_r.sck_d & ~pause;
        st_nxt.rd_start = 1'b0;
        st_nxt.wr_exec = 1'b0;
        st_nxt.pop = 1'b0;
        st_nxt.flush = 1'b0;
        // power-up write delay
        if (!st_r.puw_done) begin
            st_nxt.puw_cnt = st_r.puw_cnt + 20'h00001;
            st_nxt.puw_done = (st_r.puw_cnt == 20'(PUW_CYCLES - 1));
        end
        if (cs_hi) begin
            // chip select high ends every phase, pending actions resolve here
            if (st_r.state != flash_io_pkg::ST_IDLE) begin
                st_nxt.flush = 1'b1;
                if (st_r.pend_wr && st_r.clk_cnt == flash_io_pkg::WR_COUNT_OK
                    && !low) begin
                    st_nxt.wr_exec = 1'b1;
                end
                if (st_r.pend_sleep && st_r.clk_cnt == flash_io_pkg::WR_COUNT_OK) begin
                    st_nxt.sleep = 1'b1;
                end
                if (st_r.pend_wake) begin
                    st_nxt.sleep = 1'b0;
                end
            end
            st_nxt.state = flash_io_pkg::ST_IDLE;
            st_nxt.drive = 1'b0;
            st_nxt.pend_wr = 1'b0;
            st_nxt.pend_sleep = 1'b0;
            st_nxt.pend_wake = 1'b0;
        end else begin
            if (rise) begin
                st_nxt.clk_cnt = st_r.clk_cnt + 3'h1;
            end
            case (st_r.state)
                flash_io_pkg::ST_IDLE: begin
                    if (st_r.cs_d) begin
                        st_nxt.state = flash_io_pkg::ST_INSTR;
                        st_nxt.cnt = 6'h00;
                        st_nxt.clk_cnt = 3'h0;
                        st_nxt.grp = 3'h0;
                    end
                end
                flash_io_pkg::ST_INSTR: begin
                    if (rise) begin
                        cmd_new = {st_r.cmd[6:0], st_r.f[flash_io_pkg::PIN_IO0]};
                        st_nxt.cmd = cmd_new;
                        st_nxt.cnt = st_r.cnt + 6'h01;
                        if (st_r.cnt == flash_io_pkg::INSTR_LAST) begin
                            st_nxt.state = flash_io_pkg::ST_SINK;
                            st_nxt.cnt = 6'h00;
                            if (low) begin
                                st_nxt.state = flash_io_pkg::ST_SINK;
                            end else if (st_r.sleep) begin
                                st_nxt.pend_wake =
                                    (cmd_new == flash_io_pkg::WAKE_FROM_SLEEP_CMD);
                            end else if (flash_io_pkg::is_write_cmd(cmd_new)) begin
                                st_nxt.pend_wr = st_r.puw_done;
                            end else begin
                                case (cmd_new)
                                    flash_io_pkg::CMD_DUAL_IO: begin
                                        st_nxt.state = flash_io_pkg::ST_MIN;
                                        st_nxt.quad = 1'b0;
                                    end
                                    flash_io_pkg::CMD_QUAD_IO: begin
                                        st_nxt.quad = 1'b1;
                                        if (quad_enable_bit) begin
                                            st_nxt.state = flash_io_pkg::ST_MIN;
                                        end
                                    end
                                    flash_io_pkg::CMD_DUAL_OUT: begin
                                        st_nxt.state = flash_io_pkg::ST_SADDR;
                                        st_nxt.quad = 1'b0;
                                    end
                                    flash_io_pkg::CMD_QUAD_OUT: begin
                                        st_nxt.quad = 1'b1;
                                        if (quad_enable_bit) begin
                                            st_nxt.state = flash_io_pkg::ST_SADDR;
                                        end
                                    end
                                    flash_io_pkg::CMD_SLEEP: begin
                                        st_nxt.pend_sleep = 1'b1;
                                    end
                                    default: begin
                                        st_nxt.state = flash_io_pkg::ST_SINK;
                                    end
                                endcase
                            end
                        end
                    end
                end
                flash_io_pkg::ST_SADDR: begin
                    if (rise) begin
                        am_new = {st_r.am[30:0], st_r.f[flash_io_pkg::PIN_IO0]};
                        st_nxt.am = am_new;
                        st_nxt.cnt = st_r.cnt + 6'h01;
                        if (st_r.cnt == flash_io_pkg::SADDR_LAST) begin
                            st_nxt.rd_addr = am_new[23:0];
                            st_nxt.rd_start = 1'b1;
                            st_nxt.state = flash_io_pkg::ST_LAT;
                            st_nxt.cnt = flash_io_pkg::OUT_CMD_LAT;
                        end
                    end
                end
                flash_io_pkg::ST_MIN: begin
                    // write-protect is never looked at in these phases
                    if (rise) begin
                        am_new = st_r.quad ? {st_r.am[27:0], st_r.f[3:0]}
                                           : {st_r.am[29:0], st_r.f[1:0]};
                        st_nxt.am = am_new;
                        st_nxt.cnt = st_r.cnt + 6'h01;
                        if (st_r.cnt == (st_r.quad ? flash_io_pkg::QIN_LAST
                                                   : flash_io_pkg::DIN_LAST)) begin
                            st_nxt.rd_addr = am_new[31:8];
                            st_nxt.rd_start = 1'b1;
                            lat = st_r.quad ? {2'b00, latency_count_field}
                                            : flash_io_pkg::DUAL_IO_LAT;
                            st_nxt.cnt = lat;
                            st_nxt.state = (lat == 6'h00) ? flash_io_pkg::ST_OUT
                                                          : flash_io_pkg::ST_LAT;
                        end
                    end
                end
                flash_io_pkg::ST_LAT: begin
                    // line values are not sampled, drivers stay off
                    if (rise) begin
                        st_nxt.cnt = st_r.cnt - 6'h01;
                        if (st_r.cnt == 6'h01) begin
                            st_nxt.state = flash_io_pkg::ST_OUT;
                        end
                    end
                end
                flash_io_pkg::ST_OUT: begin
                    // drive starts on the falling edge that ends latency
                    if (fall) begin
                        st_nxt.drive = 1'b1;
                        if (st_r.grp == 3'h0) begin
                            byte_v = fifo_valid ? fifo_data : flash_io_pkg::UNDERRUN_FILL;
                            st_nxt.pop = fifo_valid;
                            st_nxt.grp = st_r.quad ? flash_io_pkg::QUAD_GROUPS_LAST
                                                   : flash_io_pkg::DUAL_GROUPS_LAST;
                        end else begin
                            byte_v = st_r.sh;
                            st_nxt.grp = st_r.grp - 3'h1;
                        end
                        st_nxt.dout = st_r.quad ? byte_v[7:4]
                                                : {2'b00, byte_v[7:6]};
                        st_nxt.sh = st_r.quad ? {byte_v[3:0], 4'h0}
                                              : {byte_v[5:0], 2'b00};
                    end
                end
                flash_io_pkg::ST_SINK: begin
                    st_nxt.state = flash_io_pkg::ST_SINK;
                end
                default: begin
                    st_nxt.state = flash_io_pkg::ST_IDLE;
                end
            endcase
        end
        // pins float while paused or outside the output phase
        st_nxt.oe = (st_nxt.drive && !pause && !cs_hi)
                    ? (st_r.quad ? flash_io_pkg::QUAD_LINES : flash_io_pkg::DUAL_LINES)
                    : 4'h0;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign io_out = st_r.dout;
    assign io_oe = st_r.oe;
    assign rd_start = st_r.rd_start;
    assign rd_addr = st_r.rd_addr;
    assign wr_exec = st_r.wr_exec;
    assign wr_cmd = st_r.cmd;
    assign deep_sleep_state = st_r.sleep;
    assign write_allowed = st_r.puw_done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_lat_no_drive: assert property (
        (st_r.state == flash_io_pkg::ST_LAT) |-> (st_r.oe == 4'h0))
        else $error("lines driven during latency");
    a_dual_width: assert property (
        (st_r.oe != 4'h0 && !st_r.quad) |-> (st_r.oe == 4'h3 && st_r.dout[3:2] == 2'b00))
        else $error("dual output uses wrong lines");
    a_quad_width: assert property (
        (st_r.oe != 4'h0 && st_r.quad) |-> (st_r.oe == 4'hF))
        else $error("quad output not on four lines");
    a_cs_ends_cmd: assert property (
        st_r.f[flash_io_pkg::PIN_CS] |=> (st_r.state == flash_io_pkg::ST_IDLE && st_r.oe == 4'h0))
        else $error("command not ended by chip select");
    a_pause_float: assert property (
        (!quad_enable_bit && !st_r.f[flash_io_pkg::PIN_PAUSE] && !st_r.f[flash_io_pkg::PIN_CS]
         && st_r.state != flash_io_pkg::ST_IDLE) |=> (st_r.oe == 4'h0))
        else $error("outputs driven while paused");
    a_wr_count: assert property (
        st_r.wr_exec |-> (st_r.clk_cnt == 3'h0 && $past(st_r.pend_wr)))
        else $error("write executed with bad clock count");
    a_wr_after_puw: assert property (
        st_r.wr_exec |-> st_r.puw_done)
        else $error("write executed before power-up delay");
    a_wr_low_supply: assert property (
        st_r.wr_exec |-> !$past(st_r.f[flash_io_pkg::PIN_LOW]))
        else $error("write executed under low supply");
    a_sleep_no_read: assert property (
        st_r.rd_start |-> !st_r.sleep)
        else $error("read started in deep sleep");
    a_quad_needs_qe: assert property (
        (st_r.rd_start && st_r.quad) |-> $past(quad_enable_bit, 2))
        else $error("quad read without quad enable");
    a_quad_lat_len: assert property (
        (st_r.state == flash_io_pkg::ST_LAT && $past(st_r.state) == flash_io_pkg::ST_MIN
         && st_r.quad) |-> (st_r.cnt == {2'b00, $past(latency_count_field)}))
        else $error("quad latency length wrong");

    c_dual_out: cover property (st_r.oe == 4'h3);
    c_quad_out: cover property (st_r.oe == 4'hF);
    c_write: cover property (st_r.wr_exec);
    c_wake: cover property ($fell(st_r.sleep));

endmodule

// ### include/flash_io_pkg.sv
package flash_io_pkg;

    // ------------------------------------------------------------
    // clock and power-up timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int PUW_TIME_US = 1000;
    localparam int PUW_CYCLES_DEF = PUW_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------
    // instruction opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_DUAL_OUT = 8'h3B;
    localparam logic [7:0] CMD_DUAL_IO = 8'hBB;
    localparam logic [7:0] CMD_QUAD_OUT = 8'h6B;
    localparam logic [7:0] CMD_QUAD_IO = 8'hEB;
    localparam logic [7:0] CMD_SLEEP = 8'hB9;
    localparam logic [7:0] WAKE_FROM_SLEEP_CMD = 8'hAB;
    localparam logic [7:0] CMD_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_QUAD_PROGRAM = 8'h32;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;

    // ------------------------------------------------------------
    // synchroniser bit positions
    // ------------------------------------------------------------
    localparam int PIN_IO0 = 0;
    localparam int PIN_PAUSE = 3;
    localparam int PIN_SCK = 4;
    localparam int PIN_CS = 5;
    localparam int PIN_LOW = 6;
    localparam logic [6:0] SYNC_RESET = 7'h00;

    // ------------------------------------------------------------
    // phase lengths, in serial clock cycles (last index, latencies as cycle counts)
    // ------------------------------------------------------------
    localparam logic [5:0] INSTR_LAST = 6'h07;
    localparam logic [5:0] SADDR_LAST = 6'h17;
    localparam logic [5:0] DIN_LAST = 6'h0F;
    localparam logic [5:0] QIN_LAST = 6'h07;
    localparam logic [5:0] OUT_CMD_LAT = 6'h08;
    localparam logic [5:0] DUAL_IO_LAT = 6'h00;
    localparam logic [2:0] WR_COUNT_OK = 3'h0;
    localparam logic [2:0] DUAL_GROUPS_LAST = 3'h3;
    localparam logic [2:0] QUAD_GROUPS_LAST = 3'h1;
    localparam logic [3:0] DUAL_LINES = 4'h3;
    localparam logic [3:0] QUAD_LINES = 4'hF;
    localparam logic [7:0] UNDERRUN_FILL = 8'hFF;

    // ------------------------------------------------------------
    // read data buffer
    // ------------------------------------------------------------
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;

    // ------------------------------------------------------------
    // interface phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_INSTR = 3'h1,
        ST_SADDR = 3'h3,
        ST_MIN = 3'h2,
        ST_LAT = 3'h6,
        ST_OUT = 3'h7,
        ST_SINK = 3'h5
    } phase_t;

    // commands that can alter the array or status
    function automatic logic is_write_cmd(input logic [7:0] c);
        is_write_cmd = (c == CMD_PROGRAM) || (c == CMD_QUAD_PROGRAM) ||
                       (c == CMD_SECTOR_ERASE) || (c == CMD_BLOCK_ERASE) ||
                       (c == CMD_CHIP_ERASE) || (c == CMD_WRITE_STATUS);
    endfunction

endpackage

// ### logic/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
        logic rdy;
        logic vld;
    } fifo_t;

    fifo_t st_r;
    fifo_t st_nxt;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        push = in_valid & st_r.rdy;
        pop = out_ready & st_r.vld;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.count = st_r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush) begin
            st_nxt.wp = '0;
            st_nxt.rp = '0;
            st_nxt.count = '0;
        end
        st_nxt.rdy = (st_nxt.count != FULL_COUNT);
        st_nxt.vld = (st_nxt.count != '0);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign in_ready = st_r.rdy;
    assign out_valid = st_r.vld;
    assign out_data = st_r.mem[st_r.rp];

endmodule

// ### verif/spi_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host side of the serial link, mode 0
// ----------------------------------------
module spi_host_model (
    input wire logic clk,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    output logic sck,
    output logic cs_n,
    output logic [3:0] h_v,
    output logic [3:0] h_oe
);
    initial begin
        {sck, h_v, h_oe} = 9'h000;
        cs_n = 1'b1;
    end
    // one 800 ns cycle from a clock edge: set lines, rise, sample before fall
    task automatic cyc(input logic [3:0] v, input logic [3:0] oe, output logic [7:0] q);
        h_v <= v;
        h_oe <= oe;
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk) q = {io_oe, io_out};
        @(posedge clk) sck <= 1'b0;
    endtask
    // select change with idle gap
    task automatic sel(input logic s);
        repeat (6) @(posedge clk);
        cs_n <= s;
    endtask
endmodule

// ### verif/tb_multi_io_serial_flash_interface.sv
`timescale 1ns/1ps
module tb_multi_io_serial_flash_interface;
    logic clk, rst, sck, cs_n, qe, inh, rd_valid, rd_start, rd_ready, wr_exec, ds, wa, nz;
    logic [3:0] io_in, io_out, io_oe, h_v, h_oe, lat;
    logic [7:0] rd_data, wr_cmd, q, b;
    logic [23:0] rd_addr, gv, aq[$], dq[$], wq[$];
    logic [31:0] w;
    logic [7:0] wc[6] = '{8'h02, 8'h32, 8'h20, 8'hD8, 8'hC7, 8'h01};
    int error_cnt, n_checks, seed, nb, l;
    event got;
    // released lines see a toggling level
    assign io_in = (io_oe & io_out) | (~io_oe & ((h_oe & h_v) | (~h_oe & {4{nz}})));
    assign rd_valid = nb != 0;
    multi_io_serial_flash_interface #(.PUW_CYCLES(150)) dut (.clk(clk), .rst(rst), .sck(sck),
        .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(qe),
        .latency_count_field(lat), .write_inhibit_voltage(inh), .rd_start(rd_start),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .wr_exec(wr_exec), .wr_cmd(wr_cmd), .deep_sleep_state(ds), .write_allowed(wa));
    spi_host_model host (.clk(clk), .io_out(io_out), .io_oe(io_oe), .sck(sck), .cs_n(cs_n),
        .h_v(h_v), .h_oe(h_oe));
    task automatic cmp(input logic [23:0] a, input logic [23:0] e);
        n_checks++;
        if (a !== e) begin
            error_cnt++;
            $display("mismatch %0t got %h want %h", $time, a, e);
        end
    endtask
    task automatic finish_test();
        error_cnt += wq.size() + aq.size();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input int n);
        host.sel(1'b0);
        for (int i = 0; i < n; i++) host.cyc({3'h4, op[7 - i % 8]}, 4'h9, q);
        host.sel(1'b1);
        repeat (8) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] op, input int n, input int nl, input int a);
        logic [3:0] m, k;
        m = n == 2 ? 4'h3 : 4'hF;
        k = n == 2 ? 4'h8 : 4'h0;
        w = $random(seed);
        aq.push_back(w[31:8]);
        host.sel(1'b0);
        for (int i = 0; i < 8; i++) host.cyc({3'h4, op[7 - i]}, 4'h9, q);
        for (int i = 0; i < (a == 1 ? 24 : 32 / n); i++) begin
            if (a == 1) host.cyc({3'h4, w[31]}, 4'h9, q);
            else host.cyc((w[31:28] >> (4 - n)) | k, m | k, q);
            w = w << a;
        end
        for (int i = 0; i < nl; i++) begin
            host.cyc(k, k, q);
            cmp(q[7:4], 0);
        end
        for (int j = 0; j < 3; j++) begin
            b = 0;
            for (int g = 0; g < 8 / n; g++) begin
                host.cyc(k, k, q);
                cmp(q[7:4], m);
                b = (b << n) | (q[3:0] & m);
            end
            gv = b;
            ->got;
        end
        cmd(8'h00, 0);
        cmp(io_oe, 0);
        dq.delete();
    endtask
    // core feed and result watchers
    always @(posedge clk) begin
        nz <= ~nz;
        if (rd_start === 1'b1) begin
            cmp(rd_addr, aq.pop_front());
            nb <= 34;
        end else if (rd_valid && rd_ready === 1'b1) begin
            dq.push_back(rd_data);
            rd_data <= $random(seed);
            nb <= nb - 1;
        end
        if (wr_exec === 1'b1) cmp(wr_cmd, wq.size() ? wq.pop_front() : 24'hFFFFFF);
    end
    always @(got) cmp(gv, dq.pop_front());
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        {qe, inh, lat, rd_data, nz, nb, error_cnt, n_checks} = 0;
        rst = 1'b1;
        seed = 82;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cmd(8'h02, 8);
        for (int i = 0; i < 300 && wa !== 1'b1; i++) @(posedge clk);
        cmp(wa, 1);
        if (wa !== 1'b1) finish_test();
        foreach (wc[i]) begin
            wq.push_back(wc[i]);
            cmd(wc[i], 8);
            cmd(wc[i], 12);
        end
        inh <= 1'b1;
        cmd(8'h02, 8);
        inh <= 1'b0;
        cmd(8'hB9, 8);
        cmd(8'h20, 8);
        cmp(ds, 1);
        cmd(8'hAB, 8);
        wq.push_back(8'h20);
        cmd(8'h20, 8);
        wq.push_back(8'h02);
        host.sel(1'b0);
        host.cyc(4'h1, 4'h9, q);
        cmd(8'h02, 8);
        cmd(8'hEB, 8);
        $display("write tests done");
        rd(8'hBB, 2, 0, 2);
        rd(8'h3B, 2, 8, 1);
        qe <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            l = i ? 0 : $random(seed) & 15;
            lat <= l[3:0];
            rd(8'hEB, 4, l, 4);
        end
        rd(8'h6B, 4, 8, 1);
        $display("read tests done");
        finish_test();
    end
endmodule
